// file: rtl/tbm_pkg.sv
// What this block does
// - Servo-to-host buffer empty when bit 13 equals 15.
// - Servo-to-host buffer is indirect C0 through FF.
// - Host reads it at addresses 40 through 7F.
// - Host-to-servo buffer empty when bit 14 equals 12.
// - Servo reads host-to-servo data, then inverts 14.
// - Host-to-servo buffer is indirect 80 through BF.
// - Host writes it at addresses 0 through 3F.
// - Servo loads buffer only while 15 equals 13.
// - No servo writes while 13 and 15 differ.
// - Servo writes words first, then inverts 15.
// - Comms light while active; access restarts watchdog.
// - Internal fault on force bit or fatal error.
// - Internal fault on watchdog expiry.
// - External fault: panel absent, no aux, fatal.
// - Mode light on normal, dark in local manual.
// - Contingency light follows contingency condition.
// - Seating light and loop-detuned light per channel.
package tbm_pkg;

	// ----------------------------------------
	// Register indices (byte address is four times the index).
	// ----------------------------------------
	localparam logic [9:0] CFG_IDX      = 10'h00e;  // Error status and configuration.
	localparam logic [9:0] IND_IDX      = 10'h010;  // Indicator state, read only.
	localparam logic [9:0] BUF_BASE_IDX = 10'h100;  // Host buffer window base.
	localparam logic [7:0] HOST_H2S_LO  = 8'h00;    // Host-to-servo host addresses.
	localparam logic [7:0] HOST_H2S_HI  = 8'h3f;
	localparam logic [7:0] HOST_S2H_LO  = 8'h40;    // Servo-to-host host addresses.
	localparam logic [7:0] HOST_S2H_HI  = 8'h7f;
	localparam logic [7:0] IND_H2S_LO   = 8'h80;    // Host-to-servo indirect range.
	localparam logic [7:0] IND_H2S_HI   = 8'hbf;
	localparam logic [7:0] IND_S2H_LO   = 8'hc0;    // Servo-to-host indirect range.
	localparam logic [7:0] IND_S2H_HI   = 8'hff;
	localparam logic [7:0] HOST_TO_IND  = 8'h80;    // Host address plus this is indirect.

	// ----------------------------------------
	// Field positions and reset values.
	// ----------------------------------------
	localparam int FORCE_ERR_BIT = 1;   // Force-error configuration bit.
	localparam int H2S_HOST_BIT  = 12;  // Host-owned host-to-servo control bit.
	localparam int S2H_HOST_BIT  = 13;  // Host-owned servo-to-host status bit.
	localparam int H2S_SERVO_BIT = 14;  // Servo-owned host-to-servo status bit.
	localparam int S2H_SERVO_BIT = 15;  // Servo-owned servo-to-host control bit.
	localparam logic TOGGLE_RST  = 1'b0;  // Reset value of all toggle bits.

	// ----------------------------------------
	// Timing.
	// ----------------------------------------
	localparam int CLK_HZ   = 10_000_000;  // Core clock rate.
	localparam int WDOG_MS  = 100;         // Watchdog timeout in milliseconds.
	localparam int WDOG_CYC = (CLK_HZ / 1000) * WDOG_MS;  // Longest time, rounded down.

	// Status levels from the panel pins and servo logic.
	typedef struct packed {
		logic       fatal;         // Fatal error present.
		logic       panel_absent;  // Operator panel not connected.
		logic       aux_missing;   // Auxiliary voltage missing.
		logic [1:0] local_manual;  // Channel in local manual operation.
		logic [1:0] contingency;   // Channel in contingency condition.
		logic [1:0] seating;       // Seating or backseating active.
		logic [1:0] detuned;       // Proportional-integral loop detuned.
	} tbm_stat_s;

	// Indicator outputs.
	typedef struct packed {
		logic       comms;                   // Communications indicator.
		logic       int_fault;               // Internal fault indicator.
		logic       ext_fault;               // External fault indicator.
		logic [1:0] mode;                    // Mode indicator per channel.
		logic [1:0] contingency_indicator;   // Contingency indicator per channel.
		logic [1:0] seating_indicator;       // Seating indicator per channel.
		logic [1:0] loop_detuned_indicator;  // Loop detuned indicator per channel.
	} tbm_led_s;

endpackage

// file: rtl/tbm_mailbox.sv
`timescale 1ns/1ps
module tbm_mailbox #(
	parameter int DW          = 16,
	parameter int DEPTH       = 64,
	parameter int WDOG_CYCLES = tbm_pkg::WDOG_CYC
) (
	// Clock and reset.
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	// APB slave, host side.
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Servo side, loading the servo-to-host buffer.
	input  wire logic              s2h_wr_i,
	input  wire logic [7:0]        s2h_addr_i,
	input  wire logic [DW-1:0]     s2h_data_i,
	input  wire logic              s2h_send_i,
	output logic                   s2h_free_o,
	// Servo side, unloading the host-to-servo buffer.
	input  wire logic              h2s_rd_i,
	input  wire logic [7:0]        h2s_addr_i,
	output logic      [DW-1:0]     h2s_rdata_o,
	input  wire logic              h2s_done_i,
	output logic                   h2s_full_o,
	// Status levels and indicators.
	input  wire tbm_pkg::tbm_stat_s stat_i,
	output tbm_pkg::tbm_led_s       led_o
);

	// ----------------------------------------
	// Declarations.
	// ----------------------------------------
	logic [DW-1:0]       h2s_mem [DEPTH];  // Host-to-servo words.
	logic [DW-1:0]       s2h_mem [DEPTH];  // Servo-to-host words.
	logic                tog12, tog13;     // Host-owned toggle bits.
	logic                tog14, tog15;     // Servo-owned toggle bits.
	logic                force_err;        // Force-error configuration bit.
	logic [31:0]         wdog_cnt;         // Cycles since last host access.
	logic                wdog_exp;         // Watchdog has expired.
	logic                seen;             // At least one host access done.
	tbm_pkg::tbm_stat_s  stat_m, stat_s;   // Two-stage input synchroniser.
	logic [9:0]          idx;              // Register index from paddr.
	logic [7:0]          host_a;           // Host buffer address.
	logic                in_buf;           // Access falls in the buffer window.
	logic                setup, done;      // APB setup and completion.
	logic [31:0]         next_rdata;       // Read data for the pending read.
	logic                next_err;         // Unmapped access.
	logic                s2h_eq, h2s_eq;   // Buffer empty conditions.

	assign idx      = paddr_i[11:2];
	assign host_a   = 8'(idx - tbm_pkg::BUF_BASE_IDX);
	// The window offset is compared at full index width, so no higher index aliases.
	assign in_buf   = (idx >= tbm_pkg::BUF_BASE_IDX)
		&& ((idx - tbm_pkg::BUF_BASE_IDX) <= 10'(tbm_pkg::HOST_S2H_HI));
	assign setup    = psel_i && !penable_i;
	assign done     = psel_i && penable_i;
	assign pready_o = 1'b1;  // Every access completes with no wait state.

	assign s2h_eq     = (tog13 == tog15);
	assign h2s_eq     = (tog14 == tog12);
	assign s2h_free_o = s2h_eq;
	assign h2s_full_o = !h2s_eq;

	// ----------------------------------------
	// Input synchroniser.
	// ----------------------------------------

	// The status levels come from pins, so they pass two flip-flops.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			stat_m <= '0;
			stat_s <= '0;
		end else begin
			stat_m <= stat_i;
			stat_s <= stat_m;
		end
	end

	// ----------------------------------------
	// APB read path and error answer.
	// ----------------------------------------

	// Decode the pending access; if and else-if chain by index.
	always_comb begin
		next_rdata = '0;
		next_err   = 1'b0;
		if (idx == tbm_pkg::CFG_IDX) begin
			next_rdata[tbm_pkg::FORCE_ERR_BIT] = force_err;
			next_rdata[tbm_pkg::H2S_HOST_BIT]  = tog12;
			next_rdata[tbm_pkg::S2H_HOST_BIT]  = tog13;
			next_rdata[tbm_pkg::H2S_SERVO_BIT] = tog14;
			next_rdata[tbm_pkg::S2H_SERVO_BIT] = tog15;
		end else if (idx == tbm_pkg::IND_IDX) begin
			next_rdata[$bits(tbm_pkg::tbm_led_s)-1:0] = led_o;
		end else if (in_buf && host_a >= tbm_pkg::HOST_S2H_LO) begin
			next_rdata[DW-1:0] = s2h_mem[6'(host_a - tbm_pkg::HOST_S2H_LO)];
		end else if (in_buf) begin
			// The host-to-servo buffer is write only for the host.
			next_rdata = '0;
		end else begin
			next_err = 1'b1;
		end
	end

	// Read data and error are caught in setup, so they are flops by the access phase.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prdata_o  <= '0;
			pslverr_o <= 1'b0;
		end else if (setup) begin
			prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
			pslverr_o <= next_err;
		end
	end

	// ----------------------------------------
	// Host-owned bits and the host-to-servo buffer.
	// ----------------------------------------

	// The host writes its toggle bits and force bit at completion.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tog12     <= tbm_pkg::TOGGLE_RST;
			tog13     <= tbm_pkg::TOGGLE_RST;
			force_err <= 1'b0;
		end else if (done && pwrite_i && idx == tbm_pkg::CFG_IDX) begin
			tog12     <= pwdata_i[tbm_pkg::H2S_HOST_BIT];
			tog13     <= pwdata_i[tbm_pkg::S2H_HOST_BIT];
			force_err <= pwdata_i[tbm_pkg::FORCE_ERR_BIT];
		end
	end

	// Host words land in the host-to-servo buffer only while it is empty.
	always_ff @(posedge clk_i) begin
		if (done && pwrite_i && in_buf && host_a <= tbm_pkg::HOST_H2S_HI && h2s_eq) begin
			h2s_mem[6'(host_a)] <= pwdata_i[DW-1:0];
		end
	end

	// ----------------------------------------
	// Servo side of the host-to-servo buffer.
	// ----------------------------------------

	// The servo reads words by indirect address.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			h2s_rdata_o <= '0;
		end else if (h2s_rd_i && h2s_addr_i >= tbm_pkg::IND_H2S_LO
			&& h2s_addr_i <= tbm_pkg::IND_H2S_HI) begin
			h2s_rdata_o <= h2s_mem[6'(h2s_addr_i - tbm_pkg::IND_H2S_LO)];
		end
	end

	// Bit 14 flips only when the buffer holds data and the servo is done.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tog14 <= tbm_pkg::TOGGLE_RST;
		end else if (h2s_done_i && !h2s_eq) begin
			tog14 <= !tog14;
		end
	end

	// ----------------------------------------
	// Servo side of the servo-to-host buffer.
	// ----------------------------------------

	// Servo words are taken only while the buffer is free.
	always_ff @(posedge clk_i) begin
		if (s2h_wr_i && s2h_eq && s2h_addr_i >= tbm_pkg::IND_S2H_LO) begin
			s2h_mem[6'(s2h_addr_i - tbm_pkg::IND_S2H_LO)] <= s2h_data_i;
		end
	end

	// Bit 15 flips after the words, and never while the host is unloading.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tog15 <= tbm_pkg::TOGGLE_RST;
		end else if (s2h_send_i && s2h_eq) begin
			tog15 <= !tog15;
		end
	end

	// ----------------------------------------
	// Watchdog.
	// ----------------------------------------

	// Each completed host access restarts the count; expiry holds until then.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wdog_cnt <= '0;
			wdog_exp <= 1'b0;
			seen     <= 1'b0;
		end else if (done) begin
			wdog_cnt <= '0;
			wdog_exp <= 1'b0;
			seen     <= 1'b1;
		end else if (wdog_cnt >= 32'(WDOG_CYCLES - 1)) begin
			wdog_exp <= seen;
		end else begin
			wdog_cnt <= wdog_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Indicators.
	// ----------------------------------------

	// All indicators are registered; comms and the watchdog and force parts of int_fault are not from synchronised levels.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			led_o <= '0;
		end else begin
			led_o.comms <= seen && !wdog_exp;
			led_o.int_fault <= force_err || stat_s.fatal || wdog_exp;
			led_o.ext_fault <= stat_s.panel_absent || stat_s.aux_missing || stat_s.fatal;
			led_o.mode <= ~stat_s.local_manual;
			led_o.contingency_indicator <= stat_s.contingency;
			led_o.seating_indicator      <= stat_s.seating;
			led_o.loop_detuned_indicator <= stat_s.detuned;
		end
	end

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence send_req_s;
		s2h_send_i && s2h_eq;
	endsequence

	sequence stat_path_s;
		stat_s.fatal ##1 1'b1;
	endsequence

	reset_toggle_a: assert property ($past(!rstn_i) |-> !(tog12 | tog13 | tog14 | tog15))
		else $error("toggle bits not zero after reset");
	send_flip_a: assert property (send_req_s |=> !s2h_eq)
		else $error("send did not mark buffer full");
	send_only_a: assert property ($changed(tog15) |-> $past(s2h_send_i && s2h_eq))
		else $error("bit 15 changed without a legal send");
	s2h_hold_a: assert property (!s2h_eq && s2h_wr_i |=> $stable(s2h_mem[0]))
		else $error("servo wrote while host unloading");
	release_a: assert property ($changed(tog14) |-> $past(h2s_done_i && !h2s_eq))
		else $error("bit 14 changed without data done");
	wdog_restart_a: assert property (done |=> wdog_cnt == 32'h0 ##1 wdog_cnt <= 32'h1)
		else $error("watchdog not restarted by access");
	force_fault_a: assert property (force_err |=> led_o.int_fault)
		else $error("force bit did not light internal fault");
	fatal_ext_a: assert property (stat_path_s |-> led_o.ext_fault && led_o.int_fault)
		else $error("fatal error did not light fault indicators");
	mode_led_a: assert property (stat_s.local_manual[0] |=> !led_o.mode[0])
		else $error("mode light lit in local manual");
	cfg_read_a: assert property (setup && !pwrite_i && idx == tbm_pkg::CFG_IDX
		|=> prdata_o[tbm_pkg::S2H_SERVO_BIT] == $past(tog15))
		else $error("bit 15 read back wrong");

	// The watchdog is due: host seen, no access now, count at its end.
	sequence wdog_due_s;
		seen && !done && wdog_cnt >= 32'(WDOG_CYCLES - 1);
	endsequence

	// Indicator and watchdog checks, one cycle after their sources.
	wdog_expire_a: assert property (wdog_due_s |=> wdog_exp)
		else $error("watchdog did not expire");
	comms_off_a: assert property (wdog_exp |=> !led_o.comms && led_o.int_fault)
		else $error("expired watchdog left comms lit");
	comms_on_a: assert property (seen && !wdog_exp |=> led_o.comms)
		else $error("comms light dark while host active");
	ext_fault_a: assert property (stat_s.panel_absent || stat_s.aux_missing |=> led_o.ext_fault)
		else $error("external fault not lit");
	mode_both_a: assert property (1'b1 |=> led_o.mode == ~$past(stat_s.local_manual))
		else $error("mode lights wrong");
	contingency_led_a: assert property (1'b1 |=> led_o.contingency_indicator == $past(stat_s.contingency))
		else $error("contingency lights wrong");
	seating_led_a: assert property (1'b1 |=> led_o.seating_indicator == $past(stat_s.seating)
		&& led_o.loop_detuned_indicator == $past(stat_s.detuned))
		else $error("seating or detune lights wrong");

endmodule

// file: test/tbm_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host controller model, an APB master.
// ----------------------------------------
module tbm_host_model (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// APB master side.
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [11:0]      paddr_o,
	output logic [31:0]      pwdata_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i
);
	logic last_err;  // Error flag of the latest transfer.

	// The bus is idle at time zero.
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
		last_err = 1'b0;
	end

	// One transfer held until ready is seen at a rising edge.
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_i);
		// No request is raised while the slave is held in reset.
		while (rstn_i !== 1'b1) begin
			@(posedge clk_i);
		end
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		while (pready_i !== 1'b1) begin
			@(posedge clk_i);
		end
		q = prdata_i;
		last_err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask

	task automatic give(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] c;
		logic [31:0] q;
		xfer(1'b0, 12'h038, 32'h0, c);
		if (c[tbm_pkg::H2S_HOST_BIT] === c[tbm_pkg::H2S_SERVO_BIT]) begin
			xfer(1'b1, 12'h400 + {2'b00, a, 2'b00}, {16'h0, d}, q);
		end
	endtask

	task automatic take(input logic [7:0] a, output logic [15:0] d);
		logic [31:0] q;
		xfer(1'b0, 12'h400 + {2'b00, a, 2'b00}, 32'h0, q);
		d = q[15:0];
	endtask

	task automatic flip(input int b);
		logic [31:0] c;
		logic [31:0] q;
		xfer(1'b0, 12'h038, 32'h0, c);
		c[b] = ~c[b];
		xfer(1'b1, 12'h038, c, q);
	endtask
endmodule

// file: test/tbm_mailbox_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the mailbox.
// ----------------------------------------
module tbm_mailbox_test;
	logic               clk_i, rstn_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, q;
	logic               s2h_wr_i = 1'b0, s2h_send_i = 1'b0, s2h_free_o;
	logic               h2s_rd_i = 1'b0, h2s_done_i = 1'b0, h2s_full_o;
	logic [7:0]         s2h_addr_i = 8'h00, h2s_addr_i = 8'h00;
	logic [15:0]        s2h_data_i = 16'h0, h2s_rdata_o, w;
	tbm_pkg::tbm_stat_s stat_i = '0;
	tbm_pkg::tbm_led_s  led_o;
	int                 fail_count = 0, checks_done = 0, cycles = 0;

	tbm_host_model host (.clk_i(clk_i), .rstn_i(rstn_i), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
		.pready_i(pready), .pslverr_i(pslverr));
	tbm_mailbox #(.WDOG_CYCLES(20)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .s2h_wr_i(s2h_wr_i),
		.s2h_addr_i(s2h_addr_i), .s2h_data_i(s2h_data_i), .s2h_send_i(s2h_send_i),
		.s2h_free_o(s2h_free_o), .h2s_rd_i(h2s_rd_i), .h2s_addr_i(h2s_addr_i),
		.h2s_rdata_o(h2s_rdata_o), .h2s_done_i(h2s_done_i), .h2s_full_o(h2s_full_o),
		.stat_i(stat_i), .led_o(led_o));

	// Clock at 10 MHz.
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Cut a hang short.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			wrap_up();
		end
	end

	// Compare one value and count it.
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	// Servo loads one word.
	task automatic swr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		s2h_wr_i <= 1'b1;
		s2h_addr_i <= a;
		s2h_data_i <= d;
		@(posedge clk_i);
		s2h_wr_i <= 1'b0;
	endtask

	// Servo reads one word, valid one edge later.
	task automatic srd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		h2s_rd_i <= 1'b1;
		h2s_addr_i <= a;
		@(posedge clk_i);
		h2s_rd_i <= 1'b0;
		@(negedge clk_i);
		chk("h2s_rdata", {16'h0, h2s_rdata_o}, {16'h0, e});
	endtask

	// Pulse send (0) or done (1), then settle.
	task automatic pulse(input int k);
		@(posedge clk_i);
		if (k == 0) s2h_send_i <= 1'b1; else h2s_done_i <= 1'b1;
		@(posedge clk_i);
		s2h_send_i <= 1'b0;
		h2s_done_i <= 1'b0;
		@(negedge clk_i);
	endtask

	// Indicator pattern for given levels.
	function automatic logic [31:0] led_exp(input tbm_pkg::tbm_stat_s s, input logic c,
			input logic f);
		return {21'h0, c, s.fatal | f, s.fatal | s.panel_absent | s.aux_missing,
			~s.local_manual, s.contingency, s.seating, s.detuned};
	endfunction

	// Print counts and verdict, then stop.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Reset values: both buffers empty, indicators dark, toggles zero.
	task automatic test_reset();
		chk("free", {31'h0, s2h_free_o}, 32'h1);
		chk("full", {31'h0, h2s_full_o}, 32'h0);
		chk("led", {21'h0, led_o}, 32'h0);
		host.xfer(1'b0, 12'h038, 32'h0, q);
		chk("cfg", {28'h0, q[15:12]}, 32'h0);
		chk("pslverr", {31'h0, host.last_err}, 32'h0);
		$display("reset test done");
	endtask

	// Servo sends two words; the host unloads them and frees the buffer.
	task automatic test_s2h();
		swr(8'hc0, 16'ha5a5);
		swr(8'hff, 16'h5a5a);
		pulse(0);
		chk("free", {31'h0, s2h_free_o}, 32'h0);
		swr(8'hc0, 16'h1234);
		pulse(0);
		host.xfer(1'b0, 12'h038, 32'h0, q);
		chk("bit15", {31'h0, q[15]}, 32'h1);
		host.take(8'h40, w);
		chk("s2h_lo", {16'h0, w}, 32'ha5a5);
		host.take(8'h7f, w);
		chk("s2h_hi", {16'h0, w}, 32'h5a5a);
		host.flip(tbm_pkg::S2H_HOST_BIT);
		@(negedge clk_i);
		chk("free", {31'h0, s2h_free_o}, 32'h1);
		$display("servo to host test done");
	endtask

	// The host hands two words over; the servo reads them and releases the buffer.
	task automatic test_h2s();
		host.give(8'h00, 16'h1111);
		host.give(8'h3f, 16'h2222);
		host.xfer(1'b0, 12'h400, 32'h0, q);
		chk("h2s_host_rd", q, 32'h0);
		host.flip(tbm_pkg::H2S_HOST_BIT);
		@(negedge clk_i);
		chk("full", {31'h0, h2s_full_o}, 32'h1);
		host.xfer(1'b1, 12'h400, 32'h9999, q);
		srd(8'h80, 16'h1111);
		srd(8'hbf, 16'h2222);
		pulse(1);
		chk("full", {31'h0, h2s_full_o}, 32'h0);
		host.xfer(1'b0, 12'h038, 32'h0, q);
		chk("bit14", {31'h0, q[14]}, 32'h1);
		$display("host to servo test done");
	endtask

	// Decode errors, the forced fault and every status level on its indicator.
	task automatic test_leds();
		host.xfer(1'b0, 12'h0f0, 32'h0, q);
		chk("pslverr", {31'h0, host.last_err}, 32'h1);
		host.xfer(1'b0, 12'h800, 32'h0, q);
		chk("pslverr_alias", {31'h0, host.last_err}, 32'h1);
		host.xfer(1'b1, 12'h038, 32'h3002, q);
		repeat (3) @(negedge clk_i);
		chk("led", {21'h0, led_o}, led_exp('0, 1'b1, 1'b1));
		host.xfer(1'b0, 12'h040, 32'h0, q);
		chk("ind", q, led_exp('0, 1'b1, 1'b1));
		host.xfer(1'b1, 12'h038, 32'h3000, q);
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_i);
			stat_i <= tbm_pkg::tbm_stat_s'(11'h1 << i);
			host.xfer(1'b0, 12'h038, 32'h0, q);
			repeat (4) @(negedge clk_i);
			chk("led", {21'h0, led_o}, led_exp(stat_i, 1'b1, 1'b0));
		end
		$display("indicator test done");
	endtask

	// Silence lets the watchdog expire; one access revives the comms light.
	task automatic test_wdog();
		@(posedge clk_i);
		stat_i <= '0;
		repeat (30) @(negedge clk_i);
		chk("led", {21'h0, led_o}, led_exp('0, 1'b0, 1'b1));
		host.xfer(1'b0, 12'h038, 32'h0, q);
		repeat (3) @(negedge clk_i);
		chk("comms", {31'h0, led_o.comms}, 32'h1);
		$display("watchdog test done");
	endtask

	// Main sequence.
	initial begin
		rstn_i = 1'b0;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		test_reset();
		test_s2h();
		test_h2s();
		test_leds();
		test_wdog();
		wrap_up();
	end
endmodule
